//--- dv/remote_serial_dev.sv
// behavioural remote serial device on the line side of the block
// assumes the bench sets its clock rate, carrier level and data bit
`timescale 1ns/10ps
module remote_serial_dev (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       frameOn,
  input  wire logic [7:0] halfPeriod,
  input  wire logic       dataBit,
  input  wire logic       carrierLevel,
  output logic            lineClock,
  output logic            lineData,
  output logic            carrierOut
);
  logic [7:0] phaseCnt;

  // line clock runs only inside frames and stands low between them
  always_ff @(posedge clk) begin
    if (rst || !frameOn) begin
      phaseCnt  <= 8'h00;
      lineClock <= 1'b0;
    end else if (phaseCnt == halfPeriod - 8'h01) begin
      phaseCnt  <= 8'h00;
      lineClock <= ~lineClock;
    end else begin
      phaseCnt <= phaseCnt + 8'h01;
    end
  end

  // levels change just after an edge, as a real sender would
  always_ff @(posedge clk) begin
    lineData   <= dataBit;
    carrierOut <= carrierLevel;
  end
endmodule : remote_serial_dev

//--- dv/sci_clock_sync_control_tb.sv
// self-checking bench for the serial clock and sync-line control block
// assumes one 40 MHz clock and the remote device model on the line pins
`timescale 1ns/10ps
`include "sci_clk_cfg.svh"
`define CHK(nm, want, got) begin cmpCount++; if ((got) !== (want)) begin failCount++; \
  $display("MISMATCH %s exp=%h got=%h", nm, want, got); end end
module sci_clock_sync_control_tb
  import sci_clk_pkg::*;
;
  logic       clk           = 1'b0;
  logic       rst           = 1'b1;
  logic       clkEn         = 1'b1;
  logic [7:0] regAddr       = 8'h00;
  logic [7:0] regWrData     = 8'h00;
  logic       regWr         = 1'b0;
  logic       regRd         = 1'b0;
  logic       txShiftOut    = 1'b1;
  logic       txFrameActive = 1'b0;
  logic       txBitStart    = 1'b0;
  logic       evenParitySel = 1'b0;
  logic       pFrameOn      = 1'b0;
  logic       pData         = 1'b1;
  logic       pCarrier      = 1'b0;
  logic       countOn       = 1'b0;
  logic [7:0] regRdData;
  logic       lineClock, lineData, carrierLine;
  logic       serialOutPin, serialOutOeN, serialClockOutPin, serialClockOutOeN;
  logic       frameRequestOut, frameRequestOeN, firstBitStrobeOut, rxSerialData;
  logic       rxSampleTick, txBitTick, oversample16, parityEven;
  int         txTicks, rxTicks, cycles, failCount, cmpCount;
  logic [7:0] sicTab [5] = '{8'h98, 8'h98, 8'ha8, 8'h90, 8'h9c};
  logic       carTab [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  int         expTab [5] = '{0, 10, 10, 10, 0};

  // 25 ns period
  always #12.5 clk = ~clk;

  sci_clock_sync_control dut (
    .clk, .rst, .clkEn, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .serialInPin(lineData), .rxClockInPin(lineClock), .txClockInPin(lineClock),
    .carrierDetectIn(carrierLine), .txShiftOut, .txFrameActive, .txBitStart,
    .evenParitySel, .serialOutPin, .serialOutOeN, .serialClockOutPin,
    .serialClockOutOeN, .frameRequestOut, .frameRequestOeN, .firstBitStrobeOut,
    .rxSerialData, .rxSampleTick, .txBitTick, .oversample16, .parityEven
  );

  remote_serial_dev remote (
    .clk, .rst, .frameOn(pFrameOn), .halfPeriod(8'h03), .dataBit(pData),
    .carrierLevel(pCarrier), .lineClock, .lineData, .carrierOut(carrierLine)
  );

  // tick counting window and hang guard; the ceiling is far above the run
  always @(posedge clk) begin
    cycles++;
    if (countOn) begin
      txTicks += txBitTick;
      rxTicks += rxSampleTick;
    end
    if (cycles == 20000) begin
      failCount++;
      $display("MISMATCH timeout exp=%0d got=%0d", 0, cycles);
      closeOut();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic chkReg(input string nm, input logic [7:0] a, input logic [7:0] want);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    `CHK(nm, want, regRdData)
  endtask : chkReg

  // window length is a multiple of the expected period, so phase does not matter
  task automatic countTicks(input int n);
    cyc(1);
    txTicks = 0;
    rxTicks = 0;
    countOn = 1'b1;
    cyc(n);
    countOn = 1'b0;
  endtask : countTicks

  task automatic closeOut();
    $display("compares=%0d mismatches=%0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : closeOut

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // reset values, unmapped offset and readback
    chkReg("clock_config", `CC_ADDR, `CC_RST);
    chkReg("sync_input", `SIC_ADDR, `SIC_RST);
    chkReg("sync_output", `SOC_ADDR, `SOC_RST);
    chkReg("divisor_low", `BDL_ADDR, 8'h00);
    // status: stopped divisor, carrier active low and seen low, line idle high
    chkReg("status", `STAT_ADDR, 8'h05);
    // a write while the clock enable is low must be ignored
    clkEn <= 1'b0;
    wr(`CC_ADDR, 8'hff);
    clkEn <= 1'b1;
    chkReg("frozen", `CC_ADDR, `CC_RST);
    wr(8'h10, 8'hff);
    chkReg("unmapped", 8'h10, 8'h00);
    for (int a = 8'hfb; a <= 8'hff; a++) begin
      wr(8'(a), 8'ha5);
      chkReg("readback", 8'(a), 8'ha5);
    end
    // clock pin function
    for (int m = 0; m < 4; m++) begin
      wr(`CC_ADDR, {2'(m), 6'h00});
      cyc(2);
      `CHK("clkPinOeN", 1'(m < 2), serialClockOutOeN)
    end
    // stick parity against every even select
    for (int i = 0; i < 4; i++) begin
      wr(`CC_ADDR, {7'h00, 1'(i >> 1)});
      evenParitySel <= 1'(i);
      cyc(2);
      `CHK("parityEven", 1'(i ^ (i >> 1)), parityEven)
    end
    // divider in 1x, 16x and stopped
    wr(`BDH_ADDR, 8'h00);
    wr(`BDL_ADDR, 8'h04);
    wr(`CC_ADDR, 8'h08);
    cyc(8);
    `CHK("ovs16", 1'b0, oversample16)
    countTicks(80);
    `CHK("ticks1x", 20, txTicks)
    wr(`CC_ADDR, 8'h00);
    wr(`BDL_ADDR, 8'h02);
    cyc(8);
    `CHK("ovs16", 1'b1, oversample16)
    countTicks(64);
    `CHK("ticks16x", 2, txTicks)
    for (int d = 0; d < 2; d++) begin
      wr(`BDL_ADDR, 8'(d));
      cyc(8);
      countTicks(64);
      `CHK("stopped", 0, txTicks)
    end
    // idle levels with no frame, then sync off
    wr(`BDL_ADDR, 8'h04);
    wr(`CC_ADDR, 8'hc0);
    wr(`SIC_ADDR, 8'h80);
    wr(`SOC_ADDR, 8'h50);
    cyc(2);
    for (int k = 0; k < 12; k++) begin
      cyc(1);
      `CHK("clkIdleLow", 1'b0, serialClockOutPin)
    end
    `CHK("dataIdleLow", 1'b0, serialOutPin)
    wr(`SIC_ADDR, 8'h00);
    cyc(3);
    `CHK("syncOff", 1'b1, serialOutPin)
    // transmit data invert
    wr(`SIC_ADDR, 8'h80);
    wr(`SOC_ADDR, 8'h80);
    txShiftOut    <= 1'b0;
    txFrameActive <= 1'b1;
    cyc(3);
    `CHK("txInvert", 1'b1, serialOutPin)
    @(posedge clk);
    txFrameActive <= 1'b0;
    // frame request and first-bit strobe, active high
    wr(`SOC_ADDR, 8'h0c);
    cyc(3);
    `CHK("reqIdle", 1'b0, frameRequestOut)
    @(posedge clk);
    txFrameActive <= 1'b1;
    txBitStart    <= 1'b1;
    @(posedge clk);
    txBitStart <= 1'b0;
    #1;
    `CHK("reqActive", 1'b1, frameRequestOut)
    `CHK("reqOeN", 1'b0, frameRequestOeN)
    `CHK("strobeFirst", 1'b1, firstBitStrobeOut)
    cyc(3);
    @(posedge clk);
    txBitStart <= 1'b1;
    @(posedge clk);
    txBitStart <= 1'b0;
    #1;
    `CHK("strobeSecond", 1'b0, firstBitStrobeOut)
    `CHK("reqHeld", 1'b1, frameRequestOut)
    @(posedge clk);
    txFrameActive <= 1'b0;
    cyc(3);
    `CHK("reqDone", 1'b0, frameRequestOut)
    `CHK("clkIdleHigh", 1'b1, serialClockOutPin)
    wr(`SOC_ADDR, 8'h08);
    cyc(3);
    `CHK("reqIdleLowPol", 1'b1, frameRequestOut)
    // output tristate field floats data and clock pins in sync mode
    wr(`SOC_ADDR, 8'h0a);
    cyc(2);
    `CHK("dataOeN", 1'b1, serialOutOeN)
    `CHK("clkOeN", 1'b1, serialClockOutOeN)
    // loopback, then echo with receive invert
    wr(`SIC_ADDR, 8'h03);
    wr(`CC_ADDR, 8'h02);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      txShiftOut <= 1'(v);
      pData      <= 1'(~v);
      cyc(6);
      `CHK("loopRx", 1'(v), rxSerialData)
      `CHK("loopOut", 1'b1, serialOutPin)
    end
    wr(`CC_ADDR, 8'h04);
    wr(`SIC_ADDR, 8'hc0);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      pData      <= 1'(v);
      pCarrier   <= 1'(v);
      txShiftOut <= 1'(~v);
      cyc(6);
      `CHK("echoOut", 1'(v), serialOutPin)
      `CHK("rxInvert", 1'(~v), rxSerialData)
      `CHK("echoReq", 1'(v), frameRequestOut)
    end
    // external receive clock with carrier gating and input disable
    wr(`CC_ADDR, 8'h28);
    pFrameOn <= 1'b1;
    for (int t = 0; t < 5; t++) begin
      wr(`SIC_ADDR, sicTab[t]);
      pCarrier <= carTab[t];
      cyc(8);
      countTicks(60);
      `CHK("rxTicks", expTab[t], rxTicks)
    end
    // tx clock from its pin, baud generator fed by the rx clock pin
    wr(`SIC_ADDR, 8'h00);
    wr(`CC_ADDR, 8'h58);
    cyc(8);
    countTicks(120);
    `CHK("txPinTicks", 20, txTicks)
    `CHK("baudFromRx", 5, rxTicks)
    @(posedge clk);
    pFrameOn <= 1'b0;
    closeOut();
  end
endmodule : sci_clock_sync_control_tb

//--- rtl/baud_divider.sv
// programmable divide-by-N counter for the baud clock
// assumes srcTick is a one-cycle enable already in the clk domain
`timescale 1ns/10ps
`include "sci_clk_cfg.svh"
module baud_divider
  import sci_clk_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic        srcTick,
  input  wire logic        load,
  input  wire logic [15:0] divisor,
  output logic             tick,
  output logic             level
);

  logic [15:0] count_reg;
  logic        tick_reg;
  logic        level_reg;
  logic        stopped;
  logic        wrap;

  assign stopped = divisor < `MIN_DIV;
  assign wrap    = srcTick && !load && !stopped && (count_reg == 16'd1);

  // count down, reload at one; a write reloads at once so the first
  // period is never a long leftover count
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= `BD_RST;
    end else if (clkEn) begin
      if (load || stopped) begin
        count_reg <= divisor;
      end else if (srcTick) begin
        count_reg <= wrap ? divisor : count_reg - 16'd1;
      end
    end
  end

  // one pulse per N source ticks
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_reg <= 1'b0;
    end else if (clkEn) begin
      tick_reg <= wrap;
    end
  end

  // square wave, high in the upper half of the count
  always_ff @(posedge clk) begin
    if (rst) begin
      level_reg <= 1'b0;
    end else if (clkEn) begin
      level_reg <= !stopped && (count_reg > (divisor >> 1));
    end
  end

  assign tick  = tick_reg;
  assign level = level_reg;

  property p_stopped;
    @(posedge clk) disable iff (rst)
    stopped && clkEn |=> !tick_reg [*2];
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("divider ticked while stopped");

  property p_reload;
    @(posedge clk) disable iff (rst)
    load && clkEn |=> count_reg == $past(divisor);
  endproperty
  a_reload: assert property (p_reload)
    else $error("divisor not loaded at once");

endmodule : baud_divider

//--- rtl/sci_clk_cfg.svh
// register offsets, field positions, reset values and counts for the
// serial clock and synchronous-line control block; definitions only
`ifndef SCI_CLK_CFG_SVH
`define SCI_CLK_CFG_SVH

// register offsets on the 8-bit register port
`define STAT_ADDR 8'hfa
`define CC_ADDR   8'hfb
`define BDH_ADDR  8'hfc
`define BDL_ADDR  8'hfd
`define SIC_ADDR  8'hfe
`define SOC_ADDR  8'hff

// reset values
`define CC_RST    8'h00
`define SIC_RST   8'h03
`define SOC_RST   8'h01
`define BD_RST    16'h0000

// clock_config fields
`define CC_PIN_HI 7
`define CC_PIN_LO 6
`define CC_EXTRX  5
`define CC_BSRC   4
`define CC_OVS    3
`define CC_ECHO   2
`define CC_LOOP   1
`define CC_STICK  0

// sync_input_control fields
`define SIC_SYNC  7
`define SIC_RXINV 6
`define SIC_RXEDG 5
`define SIC_CGATE 4
`define SIC_CPOL  3
`define SIC_INDIS 2

// sync_output_control fields
`define SOC_TXINV 7
`define SOC_TXIDL 6
`define SOC_CKEDG 5
`define SOC_CKIDL 4
`define SOC_FSIG  3
`define SOC_FPOL  2
`define SOC_OTRI  1

// divider limits and oversampling
`define MIN_DIV   16'd2
`define OVS_LAST  4'd15

`endif

//--- rtl/sci_clk_pkg.sv
// types shared by the serial clock control block
// assumes sci_clk_cfg.svh carries every number
package sci_clk_pkg;

  // function of the serial clock pin
  typedef enum logic [1:0] {
    PIN_GPIO     = 2'b00,
    PIN_CLK_IN   = 2'b01,
    PIN_BAUD_OUT = 2'b10,
    PIN_SYNC_OUT = 2'b11
  } clk_pin_mode_t;

  // where the transmitter stands inside a frame
  typedef enum logic [2:0] {
    FR_IDLE  = 3'b001,
    FR_FIRST = 3'b010,
    FR_REST  = 3'b100
  } frame_state_t;

endpackage : sci_clk_pkg

//--- rtl/sci_clock_sync_control.sv
// clock selection, test modes and synchronous-line control of the
// serial unit: pin muxing, baud divider, gating and frame strobes
// assumes the transmitter and receiver shift logic sit outside and
// run on clk; line pins arrive unsynchronised
//
// Function
// - two select bits set clock pin function
// - external select clocks receiver from rx pin
// - baud source: internal clock or rx pin
// - 16x or 1x clocking for both directions
// - auto echo drives output from input pin
// - loopback forces output high, loops shift data
// - stick parity inverts selected parity
// - baud counter divides by 16-bit divisor
// - divisor write reloads the counter at once
// - divisor 0 or 1 stops the generator
// - sync controls ignored unless sync enabled
// - rx invert touches received data only
// - rx clock edge select; echo copies clock
// - carrier level gates the external rx clock
// - carrier polarity; echo copies carrier to request
// - input disable ignores data and rx clock, not carrier
// - tx invert touches transmitter data only
// - tx idle level high or low
// - tx clock edge and idle level
// - frame request leads first, trails last edge
// - first-bit strobe high during first bit
// - even select picks odd or even parity
`timescale 1ns/10ps
`include "sci_clk_cfg.svh"
module sci_clock_sync_control
  import sci_clk_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clkEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  input  wire logic       serialInPin,
  input  wire logic       rxClockInPin,
  input  wire logic       txClockInPin,
  input  wire logic       carrierDetectIn,
  input  wire logic       txShiftOut,
  input  wire logic       txFrameActive,
  input  wire logic       txBitStart,
  input  wire logic       evenParitySel,
  output logic            serialOutPin,
  output logic            serialOutOeN,
  output logic            serialClockOutPin,
  output logic            serialClockOutOeN,
  output logic            frameRequestOut,
  output logic            frameRequestOeN,
  output logic            firstBitStrobeOut,
  output logic            rxSerialData,
  output logic            rxSampleTick,
  output logic            txBitTick,
  output logic            oversample16,
  output logic            parityEven
);

  logic [7:0]    cc_reg;
  logic [7:0]    sic_reg;
  logic [7:0]    soc_reg;
  logic [15:0]   bd_reg;
  logic          load_reg;
  logic [7:0]    rdData_reg;
  logic [7:0]    rdData_next;
  logic          pinMeta_reg [4];
  logic          pinSync_reg [4];
  logic [1:0]    pinPrev_reg;
  logic [3:0]    ovsCnt_reg;
  logic          frameOnPrev_reg;
  frame_state_t  frame_reg;
  frame_state_t  frame_next;
  logic [3:0]    pinRaw;
  logic          serial_in_pin;
  logic          rxCk;
  logic          txCk;
  logic          cdIn;
  clk_pin_mode_t pinMode;
  logic          syncOn;
  logic          echoOn;
  logic          loopOn;
  logic          inDis;
  logic          rxInv;
  logic          gateEn;
  logic          carrierAct;
  logic          rxEdgeOk;
  logic          extRxTick;
  logic          txSrcTick;
  logic          baudTick;
  logic          baudLevel;
  logic          rxRawBit;
  logic          txIdleLvl;
  logic          ckIdleLvl;
  logic          ckRun;
  logic          reqActLvl;
  logic          parEff;
  logic          outTri;
  logic          fsigOn;

  // line pins, order: data, rx clock, tx clock, carrier
  assign pinRaw = {carrierDetectIn, txClockInPin, rxClockInPin, serialInPin};

  // two-flop synchronisers, one per line pin
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (rst) begin
        pinMeta_reg[i] <= 1'b0;
        pinSync_reg[i] <= 1'b0;
      end else if (clkEn) begin
        pinMeta_reg[i] <= pinRaw[i];
        pinSync_reg[i] <= pinMeta_reg[i];
      end
    end
  end

  assign serial_in_pin  = pinSync_reg[0];
  assign rxCk = pinSync_reg[1];
  assign txCk = pinSync_reg[2];
  assign cdIn = pinSync_reg[3];

  // previous clock pin levels for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      pinPrev_reg <= 2'b00;
    end else if (clkEn) begin
      pinPrev_reg <= {txCk, rxCk};
    end
  end

  // every sync field is forced off while sync mode is off
  assign syncOn    = sic_reg[`SIC_SYNC];
  assign echoOn    = cc_reg[`CC_ECHO];
  assign loopOn    = cc_reg[`CC_LOOP];
  assign pinMode   = clk_pin_mode_t'(cc_reg[`CC_PIN_HI:`CC_PIN_LO]);
  assign inDis     = syncOn && sic_reg[`SIC_INDIS];
  assign rxInv     = syncOn && sic_reg[`SIC_RXINV];
  assign gateEn    = syncOn && sic_reg[`SIC_CGATE];
  assign outTri    = syncOn && soc_reg[`SOC_OTRI];
  assign fsigOn    = syncOn && soc_reg[`SOC_FSIG];
  assign txIdleLvl = !(syncOn && soc_reg[`SOC_TXIDL]);
  assign ckIdleLvl = !(syncOn && soc_reg[`SOC_CKIDL]);

  // carrier matches the programmed active level
  assign carrierAct = cdIn == (syncOn && sic_reg[`SIC_CPOL]);

  // chosen active edge of the rx clock pin, dropped when inputs are off
  assign rxEdgeOk = !inDis && ((syncOn && sic_reg[`SIC_RXEDG]) ?
                    (!rxCk && pinPrev_reg[0]) : (rxCk && !pinPrev_reg[0]));

  // carrier gate passes the rx clock only while carrier is active
  assign extRxTick = rxEdgeOk && (!gateEn || carrierAct);

  // baud generator fed from the system clock or the rx clock pin
  baud_divider u_baud (
    .clk     (clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .srcTick (cc_reg[`CC_BSRC] ? rxEdgeOk : 1'b1),
    .load    (load_reg),
    .divisor (bd_reg),
    .tick    (baudTick),
    .level   (baudLevel)
  );

  // transmit clock from the tx clock pin or the baud generator
  assign txSrcTick = (pinMode == PIN_CLK_IN) ?
                     (txCk && !pinPrev_reg[1]) : baudTick;

  // register writes; a divisor write also arms a counter reload
  always_ff @(posedge clk) begin
    if (rst) begin
      cc_reg  <= `CC_RST;
      sic_reg <= `SIC_RST;
      soc_reg <= `SOC_RST;
      bd_reg  <= `BD_RST;
    end else if (clkEn && regWr) begin
      case (regAddr)
        `CC_ADDR:  cc_reg <= regWrData;
        `BDH_ADDR: bd_reg[15:8] <= regWrData;
        `BDL_ADDR: bd_reg[7:0] <= regWrData;
        `SIC_ADDR: sic_reg <= regWrData;
        `SOC_ADDR: soc_reg <= regWrData;
        default: ;
      endcase
    end
  end

  // reload lands one cycle after the write, once bd_reg holds it
  always_ff @(posedge clk) begin
    if (rst) begin
      load_reg <= 1'b0;
    end else if (clkEn) begin
      load_reg <= regWr && (regAddr == `BDH_ADDR || regAddr == `BDL_ADDR);
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdData_next = 8'h00;
    case (regAddr)
      `STAT_ADDR: rdData_next = {4'h0, bd_reg >= `MIN_DIV, carrierAct,
                                 frameOnPrev_reg, serial_in_pin};
      `CC_ADDR:   rdData_next = cc_reg;
      `BDH_ADDR:  rdData_next = bd_reg[15:8];
      `BDL_ADDR:  rdData_next = bd_reg[7:0];
      `SIC_ADDR:  rdData_next = sic_reg;
      `SOC_ADDR:  rdData_next = soc_reg;
      default:    rdData_next = 8'h00;
    endcase
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_reg <= 8'h00;
    end else if (clkEn) begin
      rdData_reg <= regRd ? rdData_next : 8'h00;
    end
  end

  // 16x mode emits one bit tick per sixteen clock ticks
  always_ff @(posedge clk) begin
    if (rst) begin
      ovsCnt_reg <= 4'h0;
      txBitTick  <= 1'b0;
    end else if (clkEn) begin
      if (txSrcTick) begin
        ovsCnt_reg <= ovsCnt_reg + 4'h1;
      end
      txBitTick <= txSrcTick && (cc_reg[`CC_OVS] || ovsCnt_reg == `OVS_LAST);
    end
  end

  // receiver sample clock, mode flag and effective parity
  always_ff @(posedge clk) begin
    if (rst) begin
      rxSampleTick <= 1'b0;
      oversample16 <= 1'b1;
      parityEven   <= 1'b0;
    end else if (clkEn) begin
      rxSampleTick <= cc_reg[`CC_EXTRX] ? extRxTick : baudTick;
      oversample16 <= !cc_reg[`CC_OVS];
      parityEven   <= parEff;
    end
  end

  // even select gives the base type; stick flips it
  assign parEff = evenParitySel ^ cc_reg[`CC_STICK];

  // receive data path: loopback takes raw shift data, no inversion
  assign rxRawBit = inDis ? 1'b1 : (serial_in_pin ^ rxInv);

  always_ff @(posedge clk) begin
    if (rst) begin
      rxSerialData <= 1'b1;
    end else if (clkEn) begin
      rxSerialData <= loopOn ? txShiftOut : rxRawBit;
    end
  end

  // serial output; echo copies the raw pin and ignores both inverts
  always_ff @(posedge clk) begin
    if (rst) begin
      serialOutPin <= 1'b1;
      serialOutOeN <= 1'b0;
    end else if (clkEn) begin
      serialOutOeN <= outTri;
      if (loopOn) begin
        serialOutPin <= 1'b1;
      end else if (echoOn) begin
        serialOutPin <= serial_in_pin;
      end else if (!txFrameActive) begin
        serialOutPin <= txIdleLvl;
      end else begin
        serialOutPin <= txShiftOut ^ (syncOn && soc_reg[`SOC_TXINV]);
      end
    end
  end

  // frame seen last cycle; request leads clock edges by one cycle
  // and trails them by one, so the far end sees it settled
  always_ff @(posedge clk) begin
    if (rst) begin
      frameOnPrev_reg <= 1'b0;
    end else if (clkEn) begin
      frameOnPrev_reg <= txFrameActive;
    end
  end

  assign ckRun     = txFrameActive && frameOnPrev_reg;
  assign reqActLvl = syncOn && soc_reg[`SOC_FPOL];

  // clock pin function; only the sync clock is parked between frames
  always_ff @(posedge clk) begin
    if (rst) begin
      serialClockOutPin <= 1'b0;
      serialClockOutOeN <= 1'b1;
    end else if (clkEn) begin
      if (echoOn) begin
        serialClockOutPin <= rxCk;
        serialClockOutOeN <= outTri;
      end else begin
        unique case (pinMode)
          PIN_BAUD_OUT: begin
            serialClockOutPin <= baudLevel;
            serialClockOutOeN <= outTri;
          end
          PIN_SYNC_OUT: begin
            serialClockOutPin <= ckRun ?
              (baudLevel ^ (syncOn && soc_reg[`SOC_CKEDG])) : ckIdleLvl;
            serialClockOutOeN <= outTri;
          end
          PIN_GPIO, PIN_CLK_IN: begin
            serialClockOutPin <= 1'b0;
            serialClockOutOeN <= 1'b1;
          end
        endcase
      end
    end
  end

  // frame request; echo copies the carrier pin whatever the polarity
  always_ff @(posedge clk) begin
    if (rst) begin
      frameRequestOut <= 1'b1;
      frameRequestOeN <= 1'b1;
    end else if (clkEn) begin
      if (echoOn) begin
        frameRequestOut <= cdIn;
        frameRequestOeN <= outTri;
      end else if (fsigOn) begin
        frameRequestOut <= (txFrameActive || frameOnPrev_reg) ?
                           reqActLvl : !reqActLvl;
        frameRequestOeN <= outTri;
      end else begin
        frameRequestOut <= 1'b1;
        frameRequestOeN <= 1'b1;
      end
    end
  end

  // first-bit tracker: first bit lasts until the next bit starts
  always_comb begin
    frame_next = frame_reg;
    unique case (frame_reg)
      FR_IDLE:  if (txFrameActive && txBitStart) frame_next = FR_FIRST;
      FR_FIRST: begin
        if (!txFrameActive) frame_next = FR_IDLE;
        else if (txBitStart) frame_next = FR_REST;
      end
      FR_REST:  if (!txFrameActive) frame_next = FR_IDLE;
      default:  frame_next = FR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      frame_reg         <= FR_IDLE;
      firstBitStrobeOut <= 1'b0;
    end else if (clkEn) begin
      frame_reg         <= frame_next;
      firstBitStrobeOut <= fsigOn && (frame_next == FR_FIRST);
    end
  end

  assign regRdData = rdData_reg;

  property p_loop_high;
    @(posedge clk) disable iff (rst)
    clkEn && loopOn |=> serialOutPin;
  endproperty
  a_loop_high: assert property (p_loop_high)
    else $error("loopback output not high");

  property p_echo;
    @(posedge clk) disable iff (rst)
    clkEn && echoOn && !loopOn |=> serialOutPin == $past(serial_in_pin);
  endproperty
  a_echo: assert property (p_echo)
    else $error("echo output differs from input");

  property p_tx_idle;
    @(posedge clk) disable iff (rst)
    clkEn && !loopOn && !echoOn && !txFrameActive
      |=> serialOutPin == $past(txIdleLvl);
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("serial output not at idle level");

  property p_rx_data;
    @(posedge clk) disable iff (rst)
    clkEn && !loopOn |=> rxSerialData == $past(rxRawBit);
  endproperty
  a_rx_data: assert property (p_rx_data)
    else $error("received data path wrong");

  property p_stick;
    @(posedge clk) disable iff (rst)
    clkEn && evenParitySel && cc_reg[`CC_STICK] |=> !parityEven;
  endproperty
  a_stick: assert property (p_stick)
    else $error("stick parity not inverted");

  property p_gate;
    @(posedge clk) disable iff (rst)
    clkEn && cc_reg[`CC_EXTRX] && gateEn && !carrierAct |=> !rxSampleTick;
  endproperty
  a_gate: assert property (p_gate)
    else $error("rx clock passed without carrier");

  property p_ck_idle;
    @(posedge clk) disable iff (rst)
    clkEn && !echoOn && pinMode == PIN_SYNC_OUT && !txFrameActive
      |=> serialClockOutPin == $past(ckIdleLvl) && !serialClockOutOeN == !$past(outTri);
  endproperty
  a_ck_idle: assert property (p_ck_idle)
    else $error("clock output moved without frame");

  property p_req_lead;
    @(posedge clk) disable iff (rst)
    clkEn && !echoOn && fsigOn && txFrameActive && !frameOnPrev_reg
      |=> frameRequestOut == $past(reqActLvl);
  endproperty
  a_req_lead: assert property (p_req_lead)
    else $error("frame request late");

  property p_sds_fall;
    @(posedge clk) disable iff (rst)
    clkEn && firstBitStrobeOut && txBitStart |=> !firstBitStrobeOut;
  endproperty
  a_sds_fall: assert property (p_sds_fall)
    else $error("first-bit strobe held past second bit");

endmodule : sci_clock_sync_control
